/* pkg/perfsel_defs.vh */
`ifndef PERFSEL_DEFS_VH
`define PERFSEL_DEFS_VH

// ----------------------------------------
// register byte offsets and reset values
// ----------------------------------------
`define CTRL_OFF    8'h00
`define COUNT_OFF   8'h04
`define STATUS_OFF  8'h08
`define CTRL_RST    32'h0000_0000
`define COUNT_RST   32'h0000_0000

// ----------------------------------------
// control register fields
// ----------------------------------------
`define F_EVT       7:0
`define F_UMASK     15:8
`define F_EDGE      16
`define F_EN        22
`define F_CMASK     31:24

// ----------------------------------------
// event numbers
// ----------------------------------------
`define EVT_DELIVERY 8'h79
`define EVT_ICACHE  8'h80
`define EVT_XLATE   8'h85
`define EVT_PREDEC  8'h87
`define EVT_BR_EXEC 8'h88
`define EVT_BR_MISP 8'h89

// ----------------------------------------
// unit-mask bit positions
// ----------------------------------------
`define UM_QUEUE_EMPTY 1
`define UM_LEGACY    2
`define UM_DECODED   3
`define UM_SEQ_DEC   4
`define UM_SEQ_LEG   5
`define UM_IC_MISS   1
`define UM_WALK_GO   0
`define UM_WALK_DONE 1
`define UM_WALK_BUSY 2
`define UM_L2_HIT    4
`define UM_PREFIX    0
`define UM_QUEUE_FULL 2
`define UM_TAKEN     7
`define UM_NOTTAKEN  6

// ----------------------------------------
// ahb-lite encodings
// ----------------------------------------
`define HTRANS_NONSEQ 2'b10
`define HRESP_OKAY    1'b0

`endif

/* verilog/frontend_branch_event_select.v */
// Implementation choices: the AHB-Lite slave port and the address map.
`include "perfsel_defs.vh"

// What this block does
// - 79H/02H: count cycles decode queue empty
// - 79H/04H: add legacy-path uops each cycle the sequencer is idle
// - 79H/08H: add decoded-cache uops each cycle the sequencer is idle
// - 79H/10H: sequencer uops via cache; edge activations
// - threshold 1 counts non-zero cycles
// - 79H/20H: sequencer uops via legacy path
// - 79H/30H: sequencer uops from both paths
// - 79H mask 08H|10H counts both sources
// - 80H/02H: count instruction cache misses
// - 85H/01H: count misses starting page walk
// - 85H/02H: count misses with finished walk
// - 85H/04H: count cycles walk handler busy
// - 85H/10H: count second-level buffer hits
// - 87H/01H: count length-changing prefix stalls
// - 87H/04H: count instruction-queue-full stall cycles
// - 88H: executed branches, C1H conditional, FFH all
// - 88H: 41H not-taken, 81H taken conditional
// - 88H: 88H taken returns, C8H all returns
// - 88H: 90H direct calls, A0H indirect calls
// - 89H mispredicted: 41H/81H conditional branches
// - 89H: 90H direct calls, 84H indirect jumps
module frontend_branch_event_select #(
    parameter UOP_W = 3
) (
    // clock and reset
    input  wire         hclk,
    input  wire         hresetn,
    // ahb-lite slave
    input  wire         hsel,
    input  wire [31:0]  haddr,
    input  wire [1:0]   htrans,
    input  wire         hwrite,
    input  wire [2:0]   hsize,
    input  wire         hready,
    input  wire [31:0]  hwdata,
    output wire         hreadyout,
    output wire         hresp,
    output reg  [31:0]  hrdata,
    // decode queue delivery
    input  wire             instr_decode_queue_empty,
    input  wire [UOP_W-1:0] legacy_decode_path_uops,
    input  wire [UOP_W-1:0] decoded_uop_cache_uops,
    input  wire             microcode_sequencer_busy,
    // fetch and translation
    input  wire         instr_cache_miss_event,
    input  wire         xlate_walk_start,
    input  wire         xlate_walk_done,
    input  wire         page_miss_handler_busy,
    input  wire         second_level_xlate_buffer_hit,
    // pre-decode stalls
    input  wire         length_changing_prefix_stall,
    input  wire         instruction_queue_full_stall,
    // branch execution
    input  wire         branch_valid,
    input  wire [5:0]   branch_class,
    input  wire         branch_taken,
    input  wire         branch_mispredicted,
    // counter view
    output wire [31:0]  count_value,
    output wire         count_running
);

// ----------------------------------------
// helpers
// ----------------------------------------
function [5:0] pick;
    input             en;
    input [UOP_W-1:0] v;
    begin
        if (en)
            pick = {{(6-UOP_W){1'b0}}, v};
        else
            pick = 6'h00;
    end
endfunction

function [5:0] one;
    input en;
    begin
        one = {5'h00, en};
    end
endfunction

// class bits: 0 cond, 1 direct jump, 2 indirect jump,
// 3 return, 4 direct call, 5 indirect call
function br_hit;
    input [7:0] m;
    input [5:0] cls;
    input       tk;
    reg         dir_ok;
    begin
        dir_ok = (tk & m[`UM_TAKEN]) | (~tk & m[`UM_NOTTAKEN]);
        br_hit = (|(m[5:0] & cls)) & dir_ok;
    end
endfunction

// ----------------------------------------
// registers
// ----------------------------------------
reg  [31:0] ctrl_reg;
reg  [31:0] ctrl_next;
reg  [31:0] count_reg;
reg  [31:0] count_next;
reg         cond_prev_reg;
reg         wr_pend_reg;
reg  [7:0]  addr_reg;

wire [7:0]  evt   = ctrl_reg[`F_EVT];
wire [7:0]  umask = ctrl_reg[`F_UMASK];
wire [7:0]  cmask = ctrl_reg[`F_CMASK];
wire        edge_en = ctrl_reg[`F_EDGE];
wire        cnt_en  = ctrl_reg[`F_EN];

// ----------------------------------------
// ahb-lite slave
// ----------------------------------------
// zero wait states; every response is okay
assign hreadyout = 1'b1;
assign hresp     = `HRESP_OKAY;

wire take = hsel & hready & (htrans == `HTRANS_NONSEQ);
wire wr_ctrl  = wr_pend_reg & (addr_reg == `CTRL_OFF);
wire wr_count = wr_pend_reg & (addr_reg == `COUNT_OFF);

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend_reg <= 1'b0;
        addr_reg    <= 8'h00;
    end else begin
        wr_pend_reg <= take & hwrite;
        if (take)
            addr_reg <= haddr[7:0];
    end
end

// ----------------------------------------
// per-cycle quantity for the selection
// ----------------------------------------
wire       seq_busy = microcode_sequencer_busy;
wire       seq_idle = ~microcode_sequencer_busy;
wire       bok      = branch_valid;

// ----------------------------------------
// decode queue delivery sub-events
// ----------------------------------------
// legacy and cache sources split by sequencer state,
// so every mask combination sums disjoint uops
wire       en_empty   = umask[`UM_QUEUE_EMPTY];
wire       en_legacy  = umask[`UM_LEGACY] & seq_idle;
wire       en_decoded = umask[`UM_DECODED] & seq_idle;
wire       en_seq_dec = umask[`UM_SEQ_DEC] & seq_busy;
wire       en_seq_leg = umask[`UM_SEQ_LEG] & seq_busy;
reg  [5:0] qty_dlv;

// widest sum is 1 + 2 * 7, since sequencer state enables only two uop terms
always @* begin
    qty_dlv = one(en_empty & instr_decode_queue_empty)
            + pick(en_legacy, legacy_decode_path_uops)
            + pick(en_decoded, decoded_uop_cache_uops)
            + pick(en_seq_dec, decoded_uop_cache_uops)
            + pick(en_seq_leg, legacy_decode_path_uops);
end

// ----------------------------------------
// fetch, translation and pre-decode sub-events
// ----------------------------------------
wire       hit_miss   = umask[`UM_IC_MISS] & instr_cache_miss_event;
wire       hit_go     = umask[`UM_WALK_GO] & xlate_walk_start;
wire       hit_done   = umask[`UM_WALK_DONE] & xlate_walk_done;
wire       hit_busy   = umask[`UM_WALK_BUSY] & page_miss_handler_busy;
wire       hit_l2     = umask[`UM_L2_HIT] & second_level_xlate_buffer_hit;
wire       hit_prefix = umask[`UM_PREFIX] & length_changing_prefix_stall;
wire       hit_full   = umask[`UM_QUEUE_FULL] & instruction_queue_full_stall;
reg  [5:0] qty_fetch;
reg  [5:0] qty_xlate;
reg  [5:0] qty_predec;

always @* begin
    qty_fetch = one(hit_miss);
end

// walk start and walk done may fall in one cycle; both count
always @* begin
    qty_xlate = one(hit_go)
              + one(hit_done)
              + one(hit_busy)
              + one(hit_l2);
end

always @* begin
    qty_predec = one(hit_prefix)
               + one(hit_full);
end

// ----------------------------------------
// branch execution sub-events
// ----------------------------------------
// one branch a cycle; type and direction bits both gate
wire       br_sel  = br_hit(umask, branch_class, branch_taken);
wire       br_exec = bok & br_sel;
wire       br_misp = bok & branch_mispredicted & br_sel;
reg  [5:0] qty_exec;
reg  [5:0] qty_misp;

always @* begin
    qty_exec = one(br_exec);
end

always @* begin
    qty_misp = one(br_misp);
end

// ----------------------------------------
// event select
// ----------------------------------------
// unknown events never count, so a stale selection is harmless
reg  [5:0] qty;
reg        known;

always @* begin
    qty   = 6'h00;
    known = 1'b1;
    case (evt)
        `EVT_DELIVERY: begin
            qty = qty_dlv;
        end
        `EVT_ICACHE: begin
            qty = qty_fetch;
        end
        `EVT_XLATE: begin
            qty = qty_xlate;
        end
        `EVT_PREDEC: begin
            qty = qty_predec;
        end
        `EVT_BR_EXEC: begin
            qty = qty_exec;
        end
        `EVT_BR_MISP: begin
            qty = qty_misp;
        end
        default: begin
            known = 1'b0;
        end
    endcase
end

// ----------------------------------------
// threshold and edge qualification
// ----------------------------------------
// with edge clear, cmask 0 passes the raw quantity; any other value turns
// the counter into a counter of cycles with qty >= cmask
wire       active  = cnt_en & known;
wire       use_thr = (cmask != 8'h00);
wire       nz      = (qty != 6'h00);
wire       thr_ok  = ({2'b00, qty} >= cmask);
wire       cond    = use_thr ? thr_ok : nz;
wire       rise    = cond & ~cond_prev_reg;
reg  [5:0] inc;

always @* begin
    if (!active) begin
        inc = 6'h00;
    end else if (edge_en) begin
        inc = one(rise);
    end else if (use_thr) begin
        inc = one(cond);
    end else begin
        inc = qty;
    end
end

// ----------------------------------------
// register update
// ----------------------------------------
always @* begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl)
        ctrl_next = hwdata;
end

// the counter wraps silently; software must read often enough
wire [31:0] count_inc = count_reg + {{26{1'b0}}, inc};

// software write beats the increment of that cycle
always @* begin
    if (wr_count) begin
        count_next = hwdata;
    end else begin
        count_next = count_inc;
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ctrl_reg      <= `CTRL_RST;
        count_reg     <= `COUNT_RST;
        cond_prev_reg <= 1'b0;
    end else begin
        ctrl_reg      <= ctrl_next;
        count_reg     <= count_next;
        // cleared while idle so the first active cycle can edge
        cond_prev_reg <= active & cond;
    end
end

// ----------------------------------------
// read data
// ----------------------------------------
// built from next values so a read right after a write
// returns the written data
wire        rd_take     = take & ~hwrite;
wire [31:0] status_word = {{18{1'b0}}, qty, 6'h00,
                           cond_prev_reg, known};
wire [31:0] rd_word;

// unmapped offsets read zero rather than an alias
function [31:0] read_mux;
    input [7:0]  a;
    input [31:0] c;
    input [31:0] n;
    input [31:0] s;
    begin
        case (a)
            `CTRL_OFF:   read_mux = c;
            `COUNT_OFF:  read_mux = n;
            `STATUS_OFF: read_mux = s;
            default:     read_mux = 32'h0000_0000;
        endcase
    end
endfunction

assign rd_word = read_mux(haddr[7:0], ctrl_next, count_next, status_word);

// hrdata holds until the next read is taken
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
        hrdata <= rd_word;
    end
end

// ----------------------------------------
// counter view
// ----------------------------------------
// count_running is combinational: it follows a control write
// from the cycle after that write's data phase
assign count_value   = count_reg;
assign count_running = active;

endmodule

/* verif/event_select_props.sv */
module event_select_props #(
    parameter int UOP_W = 3
) (
    input logic             hclk,
    input logic             hresetn,
    input logic             hsel,
    input logic [31:0]      haddr,
    input logic [1:0]       htrans,
    input logic             hwrite,
    input logic             hready,
    input logic [31:0]      hwdata,
    input logic             hreadyout,
    input logic             hresp,
    input logic [31:0]      hrdata,
    input logic             instr_decode_queue_empty,
    input logic [UOP_W-1:0] decoded_uop_cache_uops,
    input logic             microcode_sequencer_busy,
    input logic             instr_cache_miss_event,
    input logic             page_miss_handler_busy,
    input logic [31:0]      count_value,
    input logic             count_running
);
    // shadow of the control word, rebuilt from bus writes
    logic        wr_q;
    logic [7:0]  a_q;
    logic [31:0] cfg;
    wire         busy_uops = microcode_sequencer_busy && (decoded_uop_cache_uops != '0);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            a_q  <= 8'h00;
            cfg  <= 32'h0;
        end else begin
            wr_q <= hsel && hready && htrans == 2'b10 && hwrite;
            a_q  <= haddr[7:0];
            if (wr_q && a_q == 8'h00)
                cfg <= hwdata;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_rd_cnt;
        hsel && hready && htrans == 2'b10 && !hwrite && haddr[7:0] == 8'h04 && !wr_q;
    endsequence
    a_ready_const: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_idle_hold: assert property (!count_running && !wr_q |=> $stable(count_value))
        else $error("count moved while idle");
    a_read_count: assert property (s_rd_cnt |=> hrdata == count_value)
        else $error("count read mismatch");
    a_empty_count: assert property (cfg == 32'h0040_0279 && !wr_q
        |=> count_value == $past(count_value) + $past(instr_decode_queue_empty))
        else $error("empty cycles miscounted");
    a_miss_count: assert property (cfg == 32'h0040_0280 && !wr_q
        |=> count_value == $past(count_value) + $past(instr_cache_miss_event))
        else $error("cache misses miscounted");
    a_walk_busy: assert property (cfg == 32'h0040_0485 && !wr_q
        |=> count_value == $past(count_value) + $past(page_miss_handler_busy))
        else $error("walk cycles miscounted");
    a_edge_once: assert property (cfg == 32'h0141_1079 && $stable(cfg) && !wr_q
        && busy_uops && $past(busy_uops) |=> $stable(count_value))
        else $error("edge counted a held level");
endmodule
bind frontend_branch_event_select event_select_props #(.UOP_W(UOP_W)) u_props (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata, .hreadyout,
    .hresp, .hrdata, .instr_decode_queue_empty, .decoded_uop_cache_uops,
    .microcode_sequencer_busy, .instr_cache_miss_event, .page_miss_handler_busy,
    .count_value, .count_running
);

/* verif/pipe_model.sv */
module pipe_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        fire,
    input  wire logic [23:0] ev,
    output logic      [23:0] pq
);
    timeunit 1ns;
    timeprecision 1ns;
    // strobes are same-clock; all low is a true no-event cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            pq <= 24'h0;
        else
            pq <= fire ? ev : 24'h0;
    end
endmodule

/* verif/frontend_branch_event_select_tb_top.sv */
module frontend_branch_event_select_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, fire = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [23:0] ev = 24'h0, pq;
    wire         hreadyout, hresp, cr;
    wire  [31:0] cv;
    wire         hready = hreadyout;
    int          fail_count = 0, cmp_count = 0;
    always #25 hclk = ~hclk;
    pipe_model u_pipe (.hclk, .hresetn, .fire, .ev, .pq);
    frontend_branch_event_select DUT (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready, .hwdata,
        .hreadyout, .hresp, .hrdata, .instr_decode_queue_empty(pq[0]),
        .legacy_decode_path_uops(pq[3:1]), .decoded_uop_cache_uops(pq[6:4]),
        .microcode_sequencer_busy(pq[7]), .instr_cache_miss_event(pq[8]),
        .xlate_walk_start(pq[9]), .xlate_walk_done(pq[10]), .page_miss_handler_busy(pq[11]),
        .second_level_xlate_buffer_hit(pq[12]), .length_changing_prefix_stall(pq[13]),
        .instruction_queue_full_stall(pq[14]), .branch_valid(pq[15]),
        .branch_class(pq[21:16]), .branch_taken(pq[22]), .branch_mispredicted(pq[23]),
        .count_value(cv), .count_running(cr)
    );
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int k;
        k = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1 && ++k < 64);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1 && ++k < 64);
        r = hrdata;
        if (k >= 64)
            fail_count++;
    endtask
    task automatic check(input string nm, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, x, g);
        end
    endtask
    // clear after selecting so leftovers of the last setup never leak in
    task automatic measure(input logic [31:0] c, input logic [23:0] e, input logic [31:0] x,
                           input string nm);
        logic [31:0] r;
        ahb(1'b1, 8'h00, c, r);
        ahb(1'b1, 8'h04, 32'h0, r);
        ev <= e;
        fire <= 1'b1;
        repeat (4) @(posedge hclk);
        fire <= 1'b0;
        repeat (3) @(posedge hclk);
        check({nm, " pin"}, x, cv);
        check({nm, " run"}, {31'h0, c[22]}, {31'h0, cr});
        ahb(1'b0, 8'h04, 32'h0, r);
        check(nm, x, r);
    endtask
    task automatic t_bus();
        logic [31:0] r;
        ahb(1'b0, 8'h00, 32'h0, r);
        check("ctrl reset", 32'h0, r);
        check("run reset", 32'h0, {31'h0, cr});
        ahb(1'b1, 8'h00, 32'h0040_0055, r);
        ahb(1'b0, 8'h08, 32'h0, r);
        check("status unknown", 32'h0, r);
        ahb(1'b1, 8'h00, 32'h0040_0279, r);
        ahb(1'b0, 8'h08, 32'h0, r);
        check("status known", 32'h1, r);
        ahb(1'b1, 8'h04, 32'h8000_0123, r);
        ahb(1'b0, 8'h04, 32'h0, r);
        check("count rw", 32'h8000_0123, r);
        ahb(1'b1, 8'h0c, 32'hffff_ffff, r);
        ahb(1'b0, 8'h0c, 32'h0, r);
        check("unmapped", 32'h0, r);
        $display("test bus done");
    endtask
    task automatic t_delivery();
        logic [63:0] t [12] = '{64'h0040_0279_0001_0004, 64'h0040_0479_0006_000c,
            64'h0040_0879_0050_0014, 64'h0040_1079_00d0_0014, 64'h0140_1079_00d0_0004,
            64'h0141_1079_00d0_0001, 64'h0040_2079_0086_000c, 64'h0040_3079_00d6_0020,
            64'h0040_1879_0050_0014, 64'h0040_1879_00d0_0014, 64'h0040_0479_0086_0000,
            64'h0000_0279_0001_0000};
        foreach (t[i])
            measure(t[i][63:32], {8'h0, t[i][31:16]}, {16'h0, t[i][15:0]}, "dlv");
        $display("test delivery done");
    endtask
    task automatic t_fetch();
        logic [31:0] t [9] = '{32'h8002_0804, 32'h8501_0904, 32'h8502_0a04, 32'h8504_0b04,
            32'h8510_0c04, 32'h8701_0d04, 32'h8704_0e04, 32'h8501_0a00, 32'h8701_0e00};
        foreach (t[i])
            measure({16'h0040, t[i][23:16], t[i][31:24]}, 24'h1 << t[i][15:8],
                    {24'h0, t[i][7:0]}, $sformatf("fetch %h", t[i]));
        $display("test fetch done");
    endtask
    task automatic t_branch();
        logic [31:0] t [15] = '{32'h8841_0004, 32'h8841_0100, 32'h8881_0104, 32'h88c1_0004,
            32'h88ff_5104, 32'h8888_3104, 32'h88c8_3004, 32'h8890_4104, 32'h88a0_5104,
            32'h88a0_4100, 32'h8941_0204, 32'h8941_0000, 32'h8981_0304, 32'h8990_4304,
            32'h8984_2304};
        foreach (t[i])
            measure({16'h0040, t[i][23:16], t[i][31:24]},
                    {t[i][9], t[i][8], 6'h0, 16'h8000} | (24'h1 << (16 + t[i][15:12])),
                    {24'h0, t[i][7:0]}, $sformatf("br %h", t[i]));
        $display("test branch done");
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #500_000;
        fail_count++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_bus();
        t_delivery();
        t_fetch();
        t_branch();
        stop_test();
    end
endmodule
